// >>> dkc_host_port.sv
module dkc_host_port
  import dkc_pkg::*;
#(
  parameter logic [9:0] MAX_CYL = 10'h3FF,
  parameter int STEP_SLOW = STEP_SLOW_CYC
) (
  input wire logic clk, // System clock, 10 MHz.
  input wire logic rst_n, // Asynchronous reset.
  input wire logic [9:0] io_addr, // Host I/O address.
  input wire logic io_wr, // Host write strobe.
  input wire logic io_rd, // Host read strobe.
  input wire logic [7:0] io_wdata, // Host write data.
  output logic [7:0] io_rdata, // Read data, valid after the read edge.
  output logic sel_pulse, // Controller select pulse.
  input wire logic int_en, // Interrupts enabled.
  output logic irq, // Completion interrupt.
  output logic busy, // Command in progress.
  output logic eng_start, // Start one attempt of the command.
  output logic [2:0] eng_class, // Command class.
  output logic [4:0] eng_opcode, // Command opcode.
  output logic eng_drive, // Drive number.
  output logic [4:0] eng_head, // Head number.
  output logic [1:0] cylinder_upper_bits, // Cylinder bits 9..8.
  output logic [7:0] eng_cyl_low, // Cylinder bits 7..0.
  output logic [5:0] eng_sector, // Sector number.
  output logic [7:0] eng_count, // Interleave or block count.
  output logic step_tick, // One pulse per step period while executing.
  input wire logic eng_done, // Attempt finished.
  input wire logic eng_fail, // Attempt failed.
  input wire logic [1:0] eng_etype, // Error type of the failure.
  input wire logic [3:0] eng_ecode, // Error code of the failure.
  input wire logic seek_busy // Overlapped seek still running.
);

  typedef struct packed {
    dkc_state_t st;
    logic [2:0] idx;
    logic [CMD_BYTES-1:0][7:0] command_block;
    logic [2:0] tries;
    logic reread;
    logic err;
    logic [1:0] etype;
    logic [3:0] ecode;
    logic avalid;
    logic [7:0] rdata;
    logic sel;
    logic irq;
    logic busy;
    logic start;
    logic [14:0] scnt;
    logic stick;
  } dkc_regs_t;

  dkc_regs_t s;
  dkc_regs_t next_s;

  localparam logic [14:0] SLOW_RELOAD = 15'(STEP_SLOW - 1);
  localparam logic [14:0] MID_RELOAD = 15'(STEP_MID_CYC - 1);
  localparam logic [14:0] FAST_RELOAD = 15'(STEP_FAST_CYC - 1);

  function automatic logic cmd_known(input logic [7:0] b0);
    logic [4:0] op;
    op = b0[4:0];
    if (b0[7:5] == CLASS_DISK) begin
      return op <= OP_LAST_DISK && op != OP_RESERVED_02 &&
        op != OP_RESERVED_09;
    end
    if (b0[7:5] == CLASS_DIAG) begin
      return op == OP_RAM_DIAG || op == OP_DRIVE_DIAG;
    end
    return 1'b0;
  endfunction

  function automatic logic cmd_addr(input logic [7:0] b0);
    return b0[7:5] == CLASS_DISK && b0[4:0] >= OP_ADDR_FIRST &&
      b0[4:0] <= OP_ADDR_LAST && b0[4:0] != OP_RESERVED_09;
  endfunction

  function automatic logic [14:0] step_reload(input logic [2:0] sel);
    unique case (sel)
      STEP_200US: return MID_RELOAD;
      STEP_70US: return FAST_RELOAD;
      default: return SLOW_RELOAD;
    endcase
  endfunction

  logic data_wr;
  logic data_rd;
  logic [7:0] status_reg;
  logic [7:0] done_byte;
  logic [7:0] sense_byte;
  logic [9:0] cyl_full;
  logic retryable;

  always_comb begin
    data_wr = io_wr && io_addr == ADDR_DATA;
    data_rd = io_rd && io_addr == ADDR_DATA;
    cyl_full = {s.command_block[2][7:6], s.command_block[3]};
    status_reg = 8'h00;
    status_reg[ST_REQ] = s.st == DKC_CMD || s.st == DKC_STAT ||
      s.st == DKC_SENSE;
    status_reg[ST_TO_HOST] = s.st == DKC_STAT || s.st == DKC_SENSE;
    status_reg[ST_BUSY] = s.busy;
    status_reg[ST_IRQ] = s.irq;
    done_byte = {2'b00, s.command_block[1][5], 3'b000, s.err, 1'b0};
    unique case (s.idx[1:0])
      2'd0: sense_byte = {s.avalid, 1'b0, s.etype, s.ecode};
      2'd1: sense_byte = {2'b00, s.command_block[1][5:0]};
      2'd2: sense_byte = s.command_block[2];
      default: sense_byte = s.command_block[3];
    endcase
    retryable = eng_etype == ET_MEDIA && eng_ecode != EC_BAD_TRACK;
  end
  always_comb begin
    next_s = s;
    next_s.sel = 1'b0;
    next_s.start = 1'b0;
    next_s.stick = 1'b0;
    if (io_rd) begin
      next_s.rdata = 8'h00;
      if (io_addr == ADDR_STAT) begin
        next_s.rdata = status_reg;
      end else if (io_addr == ADDR_DATA && s.st == DKC_STAT) begin
        next_s.rdata = done_byte;
      end else if (io_addr == ADDR_DATA && s.st == DKC_SENSE) begin
        next_s.rdata = sense_byte;
      end
    end
    unique case (s.st)
      DKC_IDLE: begin
        if (io_wr && io_addr == ADDR_SEL) begin
          next_s.sel = 1'b1;
          next_s.st = DKC_CMD;
          next_s.idx = 3'd0;
          next_s.busy = 1'b1;
        end
      end
      DKC_CMD: begin
        if (data_wr) begin
          next_s.command_block[s.idx] = io_wdata;
          next_s.idx = s.idx + 3'd1;
          if (s.idx == 3'(CMD_BYTES - 1)) begin
            next_s.tries = 3'd0;
            next_s.reread = 1'b0;
            next_s.err = 1'b0;
            next_s.etype = ET_DRIVE;
            next_s.ecode = EC_NONE;
            next_s.avalid = cmd_addr(s.command_block[0]);
            next_s.scnt = step_reload(io_wdata[2:0]);
            if (!cmd_known(s.command_block[0])) begin
              next_s.err = 1'b1;
              next_s.etype = ET_CMD;
              next_s.ecode = EC_BAD_CMD;
              next_s.st = DKC_STAT;
            end else if (s.command_block[0] ==
                         {CLASS_DISK, OP_READY_TEST} && seek_busy) begin
              next_s.err = 1'b1;
              next_s.ecode = EC_STILL_SEEKING;
              next_s.st = DKC_STAT;
            end else if (next_s.avalid && cyl_full > MAX_CYL) begin
              next_s.err = 1'b1;
              next_s.etype = ET_CMD;
              next_s.ecode = EC_BAD_ADDR;
              next_s.st = DKC_STAT;
            end else begin
              next_s.start = 1'b1;
              next_s.st = DKC_EXEC;
            end
            next_s.irq = next_s.st == DKC_STAT && int_en;
          end
        end
      end
      DKC_EXEC: begin
        if (s.scnt == 15'd0) begin
          next_s.scnt = step_reload(s.command_block[5][2:0]);
          next_s.stick = 1'b1;
        end else begin
          next_s.scnt = s.scnt - 15'd1;
        end
        if (eng_done) begin
          next_s.st = DKC_STAT;
          next_s.err = eng_fail;
          next_s.etype = eng_fail ? eng_etype : ET_DRIVE;
          next_s.ecode = eng_fail ? eng_ecode : EC_NONE;
          if (eng_fail && eng_etype == ET_MEDIA &&
              eng_ecode == EC_DATA_ECC && !s.reread &&
              !s.command_block[5][CTL_NO_REREAD_BIT]) begin
            next_s.reread = 1'b1;
            next_s.start = 1'b1;
            next_s.st = DKC_EXEC;
          end else if (eng_fail && retryable && s.tries < RETRY_MAX &&
                       !s.command_block[5][CTL_NO_RETRY_BIT]) begin
            next_s.tries = s.tries + 3'd1;
            next_s.start = 1'b1;
            next_s.st = DKC_EXEC;
          end
          next_s.irq = next_s.st == DKC_STAT && int_en;
        end
      end
      DKC_STAT: begin
        if (data_rd) begin
          next_s.busy = 1'b0;
          next_s.irq = 1'b0;
          next_s.idx = 3'd0;
          next_s.st = s.err ? DKC_SENSE : DKC_IDLE;
        end
      end
      DKC_SENSE: begin
        if (data_rd) begin
          next_s.idx = s.idx + 3'd1;
          if (s.idx == 3'(SENSE_BYTES - 1)) begin
            next_s.st = DKC_IDLE;
          end
        end
      end
      default: begin
        next_s.st = DKC_IDLE;
        next_s.busy = 1'b0;
        next_s.irq = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign io_rdata = s.rdata;
  assign sel_pulse = s.sel;
  assign irq = s.irq;
  assign busy = s.busy;
  assign eng_start = s.start;
  assign eng_class = s.command_block[0][7:5];
  assign eng_opcode = s.command_block[0][4:0];
  assign eng_drive = s.command_block[1][5];
  assign eng_head = s.command_block[1][4:0];
  assign cylinder_upper_bits = s.command_block[2][7:6];
  assign eng_cyl_low = s.command_block[3];
  assign eng_sector = s.command_block[2][5:0];
  assign eng_count = s.command_block[4];
  assign step_tick = s.stick;
  sequence s_take_done;
    s.st == DKC_STAT && data_rd;
  endsequence
  sequence s_last_cmd_byte;
    s.st == DKC_CMD && data_wr && s.idx == 3'(CMD_BYTES - 1);
  endsequence
  property p_select;
    @(posedge clk) disable iff (!rst_n)
      s.st == DKC_IDLE && io_wr && io_addr == ADDR_SEL
      |=> sel_pulse && !$past(sel_pulse) ##1 !sel_pulse;
  endproperty
  a_select: assert property (p_select)
    else $error("select write gave no single select pulse");
  property p_done_format;
    @(posedge clk) disable iff (!rst_n)
      s_take_done |=> io_rdata[7:6] == 2'b00 && io_rdata[4:2] == 3'b000
      && io_rdata[0] == 1'b0 && io_rdata[1] == $past(s.err);
  endproperty
  a_done_format: assert property (p_done_format)
    else $error("completion byte has wrong layout");
  property p_irq_ready;
    @(posedge clk) disable iff (!rst_n)
      $rose(s.st == DKC_STAT) && $past(int_en) |-> irq;
  endproperty
  a_irq_ready: assert property (p_irq_ready)
    else $error("no interrupt when completion byte became ready");
  property p_busy_drop;
    @(posedge clk) disable iff (!rst_n)
      s_take_done |=> !busy && !irq;
  endproperty
  a_busy_drop: assert property (p_busy_drop)
    else $error("busy still set after completion byte taken");
  property p_sense_follows;
    @(posedge clk) disable iff (!rst_n)
      s_take_done ##0 s.err |=> s.st == DKC_SENSE && s.idx == 3'd0;
  endproperty
  a_sense_follows: assert property (p_sense_follows)
    else $error("error completion not followed by sense bytes");
  property p_sense_byte0;
    @(posedge clk) disable iff (!rst_n)
      s.st == DKC_SENSE && data_rd && s.idx == 3'd0
      |=> io_rdata == {$past(s.avalid), 1'b0, $past(s.etype),
      $past(s.ecode)};
  endproperty
  a_sense_byte0: assert property (p_sense_byte0)
    else $error("first sense byte has wrong layout");
  property p_exec_after_six;
    @(posedge clk) disable iff (!rst_n)
      s_last_cmd_byte |=> s.st == DKC_EXEC || s.st == DKC_STAT;
  endproperty
  a_exec_after_six: assert property (p_exec_after_six)
    else $error("sixth command byte did not end command phase");
  property p_no_early_start;
    @(posedge clk) disable iff (!rst_n)
      eng_start |-> $past(s.st == DKC_CMD && data_wr && s.idx == 3'd5)
      || $past(s.st == DKC_EXEC && eng_done);
  endproperty
  a_no_early_start: assert property (p_no_early_start)
    else $error("attempt started before the sixth byte");
  property p_bad_track;
    @(posedge clk) disable iff (!rst_n)
      s.st == DKC_EXEC && eng_done && eng_fail && eng_etype == ET_MEDIA
      && eng_ecode == EC_BAD_TRACK |=> s.st == DKC_STAT && !eng_start;
  endproperty
  a_bad_track: assert property (p_bad_track)
    else $error("bad track was retried");
  property p_no_retry;
    @(posedge clk) disable iff (!rst_n)
      s.st == DKC_EXEC && eng_done && eng_fail
      && s.command_block[5][CTL_NO_RETRY_BIT]
      && s.command_block[5][CTL_NO_REREAD_BIT] |=> s.st == DKC_STAT;
  endproperty
  a_no_retry: assert property (p_no_retry)
    else $error("retry made with retries disabled");
  property p_step_fast;
    @(posedge clk) disable iff (!rst_n)
      s.st == DKC_EXEC && s.command_block[5][2:0] == STEP_70US
      && s.scnt == 15'd0 |=> s.scnt == FAST_RELOAD;
  endproperty
  a_step_fast: assert property (p_step_fast)
    else $error("fast step period not reloaded");
endmodule

// >>> dkc_pkg.sv
package dkc_pkg;

  // Host I/O addresses of the three ports.
  localparam logic [9:0] ADDR_DATA = 10'h0320;
  localparam logic [9:0] ADDR_STAT = 10'h0321;
  localparam logic [9:0] ADDR_SEL = 10'h0322;

  localparam int CMD_BYTES = 6;
  localparam int SENSE_BYTES = 4;
  localparam logic [2:0] RETRY_MAX = 3'h4;

  // Command classes and opcodes that the decoder needs.
  localparam logic [2:0] CLASS_DISK = 3'h0;
  localparam logic [2:0] CLASS_DIAG = 3'h7;
  localparam logic [4:0] OP_READY_TEST = 5'h00;
  localparam logic [4:0] OP_RESERVED_02 = 5'h02;
  localparam logic [4:0] OP_ADDR_FIRST = 5'h04;
  localparam logic [4:0] OP_RESERVED_09 = 5'h09;
  localparam logic [4:0] OP_ADDR_LAST = 5'h0B;
  localparam logic [4:0] OP_LAST_DISK = 5'h0F;
  localparam logic [4:0] OP_RAM_DIAG = 5'h00;
  localparam logic [4:0] OP_DRIVE_DIAG = 5'h03;

  // Control byte fields.
  localparam int CTL_NO_RETRY_BIT = 7;
  localparam int CTL_NO_REREAD_BIT = 6;
  localparam logic [2:0] STEP_200US = 3'h4;
  localparam logic [2:0] STEP_70US = 3'h5;

  // Error types.
  localparam logic [1:0] ET_DRIVE = 2'h0;
  localparam logic [1:0] ET_MEDIA = 2'h1;
  localparam logic [1:0] ET_CMD = 2'h2;
  localparam logic [1:0] ET_DIAG = 2'h3;

  // Error codes, listed by type.
  localparam logic [3:0] EC_NONE = 4'h0;
  localparam logic [3:0] EC_NO_INDEX = 4'h1;
  localparam logic [3:0] EC_SEEK_TIMEOUT = 4'h4;
  localparam logic [3:0] EC_WRITE_FAULT = 4'h6;
  localparam logic [3:0] EC_NOT_READY = 4'h4;
  localparam logic [3:0] EC_STILL_SEEKING = 4'h8;
  localparam logic [3:0] EC_ID_ECC = 4'h0;
  localparam logic [3:0] EC_DATA_ECC = 4'h1;
  localparam logic [3:0] EC_NO_START_MARK = 4'h2;
  localparam logic [3:0] EC_NO_SECTOR = 4'h4;
  localparam logic [3:0] EC_SEEK_MISMATCH = 4'h5;
  localparam logic [3:0] EC_CORR_DATA = 4'h8;
  localparam logic [3:0] EC_BAD_TRACK = 4'h9;
  localparam logic [3:0] EC_BAD_CMD = 4'h0;
  localparam logic [3:0] EC_BAD_ADDR = 4'h1;
  localparam logic [3:0] EC_RAM = 4'h0;
  localparam logic [3:0] EC_CHECKSUM = 4'h1;
  localparam logic [3:0] EC_ECC_GEN = 4'h2;

  // Step periods.
  localparam int CLK_MHZ = 10;
  localparam int STEP_SLOW_US = 3000;
  localparam int STEP_MID_US = 200;
  localparam int STEP_FAST_US = 70;
  localparam int STEP_SLOW_CYC = STEP_SLOW_US * CLK_MHZ;
  localparam int STEP_MID_CYC = STEP_MID_US * CLK_MHZ;
  localparam int STEP_FAST_CYC = STEP_FAST_US * CLK_MHZ;

  // Status register bit positions.
  localparam int ST_REQ = 0;
  localparam int ST_TO_HOST = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_IRQ = 3;

  typedef enum logic [2:0] {
    DKC_IDLE = 3'b000,
    DKC_CMD = 3'b001,
    DKC_EXEC = 3'b011,
    DKC_STAT = 3'b010,
    DKC_SENSE = 3'b110
  } dkc_state_t;

endpackage

// >>> dkc_engine_model.sv
module dkc_engine_model (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic restart, // New command; clears the attempt count.
  input wire logic eng_start, // Attempt request from the port.
  input wire logic [3:0] fails, // Attempts that fail before one passes.
  input wire logic [1:0] etype, // Type reported on a failure.
  input wire logic [3:0] ecode, // Code reported on a failure.
  input wire logic [15:0] lat, // Cycles from start to done, minus two.
  output logic eng_done, // Attempt finished.
  output logic eng_fail, // Attempt failed.
  output logic [1:0] eng_etype, // Failure type.
  output logic [3:0] eng_ecode, // Failure code.
  output logic [7:0] n_start // Attempts seen since reset.
);
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic run;
    logic done;
    logic bad;
    logic [3:0] att;
    logic [15:0] cnt;
    logic [7:0] starts;
  } dkc_eng_t;
  dkc_eng_t st;
  dkc_eng_t next_st;
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (restart) next_st.att = 4'h0;
    if (eng_start) begin
      next_st.run = 1'b1;
      next_st.cnt = lat;
      next_st.starts = st.starts + 8'h01;
    end else if (st.run && st.cnt == 16'h0000) begin
      next_st.run = 1'b0;
      next_st.done = 1'b1;
      next_st.bad = st.att < fails;
      next_st.att = st.att + 4'h1;
    end else if (st.run) begin
      next_st.cnt = st.cnt - 16'h0001;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  // Result lines show the inverse of the answer outside the done cycle.
  assign eng_done = st.done;
  assign eng_fail = st.done ? st.bad : ~st.bad;
  assign eng_etype = st.done ? etype : ~etype;
  assign eng_ecode = st.done ? ecode : ~ecode;
  assign n_start = st.starts;
endmodule

// >>> test_disk_controller_host_command_port.sv
module test_disk_controller_host_command_port
  import dkc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT = 20000;
  localparam logic [15:0] SLOW = 16'h0028;
  logic clk, rst_n, io_wr, io_rd, int_en, seek_busy;
  logic sel_pulse, irq, busy, eng_start, eng_drive, step_tick;
  logic eng_done, eng_fail;
  logic [9:0] io_addr;
  logic [7:0] io_wdata, io_rdata, n_start, d, eng_cyl_low, eng_count;
  logic [2:0] eng_class;
  logic [4:0] eng_opcode, eng_head;
  logic [1:0] cylinder_upper_bits, eng_etype, m_type;
  logic [5:0] eng_sector;
  logic [3:0] eng_ecode, m_fails, m_code;
  logic [15:0] m_lat, tick_at, tick_gap;
  logic [3:0] mc [4] = '{4'h0, 4'h2, 4'h4, 4'h8};
  logic [3:0] dc [3] = '{4'h1, 4'h4, 4'h6};
  logic [7:0] bad_op [5] = '{8'h60, 8'h02, 8'h09, 8'h10, 8'hE1};
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;

  dkc_host_port #(.MAX_CYL(10'h2FF), .STEP_SLOW(40)) i_dut (
    .clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .sel_pulse(sel_pulse), .int_en(int_en), .irq(irq), .busy(busy),
    .eng_start(eng_start), .eng_class(eng_class), .eng_opcode(eng_opcode),
    .eng_drive(eng_drive), .eng_head(eng_head),
    .cylinder_upper_bits(cylinder_upper_bits), .eng_cyl_low(eng_cyl_low),
    .eng_sector(eng_sector), .eng_count(eng_count), .step_tick(step_tick),
    .eng_done(eng_done), .eng_fail(eng_fail), .eng_etype(eng_etype),
    .eng_ecode(eng_ecode), .seek_busy(seek_busy)
  );

  dkc_engine_model i_eng (
    .clk(clk), .rst_n(rst_n), .restart(sel_pulse), .eng_start(eng_start),
    .fails(m_fails), .etype(m_type), .ecode(m_code), .lat(m_lat),
    .eng_done(eng_done), .eng_fail(eng_fail), .eng_etype(eng_etype),
    .eng_ecode(eng_ecode), .n_start(n_start)
  );

  initial clk = 1'b0;
  always #50 clk = ~clk;

  task automatic summarize();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (step_tick === 1'b1) begin
      tick_gap <= cyc[15:0] - tick_at;
      tick_at <= cyc[15:0];
    end
    if (cyc == LIMIT) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge clk);
    #1;
    io_addr = a;
    io_wdata = v;
    io_wr = 1'b1;
    @(posedge clk);
    #1;
    io_wr = 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, output logic [7:0] v);
    @(posedge clk);
    #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge clk);
    #1;
    io_rd = 1'b0;
    v = io_rdata;
  endtask

  // One whole command: select, six bytes, completion and, after an error, sense.
  task automatic cmd(input logic [47:0] blk, input logic [3:0] f,
                     input logic [5:0] err, input logic [7:0] ns,
                     input logic [7:0] s0);
    logic [7:0] n0, v, comp;
    logic [31:0] sns;
    n0 = n_start;
    m_fails = f;
    {m_type, m_code} = err;
    comp = {2'b00, blk[37], 3'b000, s0 != 8'h00, 1'b0};
    sns = {s0, 2'b00, blk[37:32], blk[31:16]};
    wr(ADDR_SEL, 8'h00);
    chk({sel_pulse, busy}, 2'b11);
    rd(ADDR_STAT, v);
    chk(v, 8'h05);
    chk(sel_pulse, 1'b0);
    for (int i = 0; i < CMD_BYTES; i++) begin
      if (i == 5) chk(n_start, n0);
      wr(ADDR_DATA, blk[47 - 8 * i -: 8]);
    end
    do rd(ADDR_STAT, v); while (v[1:0] !== 2'b11);
    chk({irq, v}, {int_en, 4'h0, int_en, 3'b111});
    chk({eng_class, eng_opcode}, blk[47:40]);
    chk({eng_drive, eng_head}, blk[37:32]);
    chk({cylinder_upper_bits, eng_sector, eng_cyl_low}, blk[31:16]);
    chk(eng_count, blk[15:8]);
    rd(ADDR_DATA, v);
    chk(v, comp);
    chk({busy, irq}, 2'b00);
    rd(ADDR_STAT, v);
    chk(v, {6'h00, comp[1], comp[1]});
    if (comp[1]) begin
      for (int k = 0; k < SENSE_BYTES; k++) begin
        rd(ADDR_DATA, v);
        chk(v, sns[31 - 8 * k -: 8]);
      end
      rd(ADDR_STAT, v);
      chk(v, 8'h00);
    end
    chk(n_start - n0, ns);
  endtask

  initial begin
    io_addr = 10'h000;
    io_wdata = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
    int_en = 1'b1;
    seek_busy = 1'b0;
    m_lat = 16'h0014;
    m_fails = 4'h0;
    m_type = 2'b00;
    m_code = 4'h0;
    tick_at = 16'h0000;
    tick_gap = 16'h0000;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd(ADDR_STAT, d);
    chk(d, 8'h00);
    wr(ADDR_STAT, 8'hFF);
    rd(ADDR_STAT, d);
    chk(d, 8'h00);
    rd(10'h300, d);
    chk(d, 8'h00);
    rd(ADDR_DATA, d);
    chk(d, 8'h00);
    cmd(48'h08E3_9A5C_1105, 4'h0, 6'h00, 8'h01, 8'h00);
    cmd(48'h08E3_9A5C_1105, 4'hF, 6'h15, 8'h05, 8'h95);
    cmd(48'h08E3_9A5C_1185, 4'hF, 6'h15, 8'h01, 8'h95);
    cmd(48'h08E3_9A5C_1105, 4'hF, 6'h19, 8'h01, 8'h99);
    cmd(48'h08E3_9A5C_1185, 4'hF, 6'h11, 8'h02, 8'h91);
    cmd(48'h08E3_9A5C_11C5, 4'hF, 6'h11, 8'h01, 8'h91);
    cmd(48'h08E3_9A5C_1185, 4'h1, 6'h11, 8'h02, 8'h00);
    for (int k = 0; k < 4; k++) begin
      cmd(48'h08E3_9A5C_1185, 4'hF, {2'b01, mc[k]}, 8'h01,
          {4'h9, mc[k]});
    end
    for (int k = 0; k < 3; k++) begin
      cmd(48'h08E3_9A5C_1105, 4'hF, {2'b00, dc[k]}, 8'h01,
          {4'h8, dc[k]});
    end
    for (int k = 0; k < 3; k++) begin
      cmd(48'hE0E3_9A5C_1105, 4'hF, {2'b11, 4'(k)}, 8'h01,
          {4'h3, 4'(k)});
    end
    cmd(48'hE3E3_9A5C_1105, 4'h0, 6'h00, 8'h01, 8'h00);
    for (int k = 0; k < 5; k++) begin
      cmd({bad_op[k], 40'hE3_9A5C_1105}, 4'h0, 6'h00, 8'h00,
          8'h20);
    end
    cmd(48'h08E3_DA5C_1105, 4'h0, 6'h00, 8'h00, 8'hA1);
    cmd(48'h08E3_9AFF_1105, 4'h0, 6'h00, 8'h01, 8'h00);
    seek_busy = 1'b1;
    cmd(48'h00E3_9A5C_1105, 4'h0, 6'h00, 8'h00, 8'h08);
    seek_busy = 1'b0;
    int_en = 1'b0;
    cmd(48'h08C5_9A5C_1105, 4'h0, 6'h00, 8'h01, 8'h00);
    int_en = 1'b1;
    for (int c = 0; c < 8; c++) begin
      m_lat = c == 4 ? 16'h1004 : c == 5 ? 16'h05DC : 16'h0078;
      cmd({40'h0B_E39A_5C11, 5'h00, c[2:0]}, 4'h0, 6'h00, 8'h01,
          8'h00);
      chk(tick_gap, c == 4 ? 16'(STEP_MID_CYC) :
          c == 5 ? 16'(STEP_FAST_CYC) : SLOW);
    end
    summarize();
  end
endmodule
